// ===== usb_desc_pkg.sv
package usb_desc_pkg;

   // Register byte offsets on the bus.
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_INTV = 8'h08;
   localparam logic [7:0] OFS_CFG_FS = 8'h0C;
   localparam logic [7:0] OFS_CFG_HS = 8'h10;
   localparam logic [7:0] OFS_DEV_FS = 8'h14;
   localparam logic [7:0] OFS_DEV_HS = 8'h18;
   localparam logic [7:0] OFS_PROTO = 8'h1C;
   localparam logic [7:0] OFS_LANG = 8'h20;

   // Single-bit field positions.
   localparam int CTRL_NV_BIT = 0;
   localparam int CTRL_SELF_BIT = 1;
   localparam int CTRL_NOWAKE_BIT = 2;
   localparam int LANG_PRESENT_BIT = 16;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_STALL_BIT = 1;

   // Operating speed codes and request type codes.
   localparam logic [1:0] SPD_FS = 2'h0;
   localparam logic [1:0] SPD_HS = 2'h1;
   localparam logic [7:0] REQ_STRING = 8'h03;
   localparam logic [7:0] REQ_ENDPOINT = 8'h05;
   localparam logic [7:0] REQ_QUAL = 8'h06;
   localparam logic [7:0] REQ_OTHER = 8'h07;

   // Endpoint descriptor contents.
   localparam logic [7:0] EP_LEN = 8'h07;
   localparam logic [7:0] TYPE_EP = 8'h05;
   localparam logic [7:0] EP_IN_ADDR = 8'h81;
   localparam logic [7:0] EP_OUT_ADDR = 8'h02;
   localparam logic [7:0] EP_INT_ADDR = 8'h83;
   localparam logic [7:0] ATTR_BULK = 8'h02;
   localparam logic [7:0] ATTR_INTR = 8'h03;
   localparam logic [15:0] MPS_FS = 16'h0040;
   localparam logic [15:0] MPS_HS = 16'h0200;
   localparam logic [15:0] MPS_SS = 16'h0400;
   localparam logic [15:0] MPS_INT = 16'h0010;
   localparam logic [7:0] BULK_INTV = 8'h00;
   localparam logic [7:0] INTV_FS_DEF = 8'h01;
   localparam logic [7:0] INTV_HS_DEF = 8'h04;
   localparam logic [7:0] INTV_SS_DEF = 8'h06;

   // Other-speed configuration contents.
   localparam logic [7:0] CFG_LEN = 8'h09;
   localparam logic [7:0] TYPE_OTHER = 8'h07;
   localparam logic [15:0] OTHER_TOTAL = 16'h0027;
   localparam logic [7:0] NUM_IF = 8'h01;
   localparam logic [7:0] CFG_VALUE = 8'h01;
   localparam logic [7:0] ICONF_DEF = 8'h00;
   localparam logic [7:0] ATTR_DEF = 8'hE0;
   localparam logic [7:0] ATTR_WAKE = 8'h20;
   localparam logic [7:0] PWR_SELF = 8'h01;
   localparam logic [7:0] PWR_BUS = 8'hFA;

   // Device qualifier and language-ID contents.
   localparam logic [7:0] QUAL_LEN = 8'h0A;
   localparam logic [7:0] TYPE_QUAL = 8'h06;
   localparam logic [15:0] BCD_DEF = 16'h0210;
   localparam logic [7:0] CLASS_DEF = 8'hFF;
   localparam logic [7:0] SUB_DEF = 8'h00;
   localparam logic [7:0] PROTO_DEF = 8'hFF;
   localparam logic [7:0] MPS0_DEF = 8'h40;
   localparam logic [7:0] NUM_CFG = 8'h01;
   localparam logic [7:0] QUAL_RSVD = 8'h00;
   localparam logic [7:0] LANG_LEN = 8'h04;
   localparam logic [7:0] TYPE_STRING = 8'h03;

   // Register reset values; CTRL and LANG reset to zero, the rest built from the defaults above.
   localparam logic [31:0] RST_CTRL = 32'h0000_0000;
   localparam logic [31:0] RST_INTV = {16'h0000, INTV_HS_DEF, INTV_FS_DEF};
   localparam logic [31:0] RST_CFG = {8'h00, PWR_BUS, ATTR_DEF, ICONF_DEF};
   localparam logic [31:0] RST_DEV = {SUB_DEF, CLASS_DEF, BCD_DEF};
   localparam logic [31:0] RST_PROTO = {16'h0000, PROTO_DEF, PROTO_DEF};
   localparam logic [31:0] RST_LANG = 32'h0000_0000;

   // Descriptor buffer address width.
   localparam int BUF_AW = 4;

   typedef enum logic [2:0] {
      K_EP_IN = 3'h0,
      K_EP_OUT = 3'h1,
      K_EP_INT = 3'h2,
      K_OTHER = 3'h3,
      K_QUAL = 3'h4,
      K_LANG = 3'h5
   } kind_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_BUILD = 3'b010,
      ST_SEND = 3'b100
   } state_t;

endpackage

// ===== desc_buf.sv
`timescale 1ns/100ps
module desc_buf #(
   parameter int WIDTH = 8,
   parameter int AW = 4
) (
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic wr_en_in,
   input wire logic [AW-1:0] wr_addr_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   input wire logic [AW-1:0] rd_addr_in,
   output logic [WIDTH-1:0] rd_data_out
);

   logic [WIDTH-1:0] mem [0:(1<<AW)-1];

   // Write port; the array itself needs no reset.
   always_ff @(posedge ref_clk_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
   end

   // Registered read, one cycle from address to data.
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         rd_data_out <= '0;
      end else begin
         rd_data_out <= mem[rd_addr_in];
      end
   end

endmodule

// ===== usb_desc_engine.sv
`timescale 1ns/100ps
// How it works
// (R1) Bulk-in endpoint descriptor is fixed: length 07h, type, address 81h, 02h.
// (R2) Bulk-out endpoint descriptor is fixed: length seven, type 05h, address 02h.
// (R3) Bulk max packet: 64 at full, 512 at high, 1024 at SuperSpeed.
// (R4) Both bulk endpoints report polling interval 00h.
// (R5) Interrupt endpoint: address 83h, attribute 03h, max packet 10h, fixed.
// (R6) Interrupt interval stored for FS and HS; defaults 04h HS, 01h FS; SS fixed at 06h.
// (R7) Other-speed and qualifier served in USB 2.0 only; stalled at SuperSpeed.
// (R8) Other-speed config: length 09h, type 07h, total 0027h, one, one.
// (R9) Other-speed config uses stored values of the opposite USB 2.0 speed.
// (R10) Other-speed power defaults 01h self-powered, FAh bus-powered; storable.
// (R11) Other-speed attributes default E0h, storable, flags alter; string index default 00h, storable.
// (R12) Qualifier length 0Ah, type 06h, last reserved byte 00h.
// (R13) Qualifier defaults 0210h, FFh, 00h, FFh, 40h, one; first four storable.
// (R14) Qualifier comes from stored device values of the opposite speed.
// (R15) Storage programmer keeps constrained fields at their default values.
// (R16) Language-ID string: length 04h, string type 03h.
// (R17) Language-ID read stalls without valid storage or with no strings.
// (R18) Otherwise the stored language-ID word is returned.
// (R19) Storage programmer places language code 0409h there.
// (R20) Requested language identifier is ignored on string reads.
// (R21) Bytes go in ascending order, LSB first, cut to requested length.
module usb_desc_engine
   import usb_desc_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   input wire logic [1:0] speed_in,
   input wire logic req_valid_in,
   input wire logic [7:0] req_type_in,
   input wire logic [7:0] req_index_in,
   input wire logic [15:0] req_langid_in,
   input wire logic [15:0] req_len_in,
   output logic req_ready_out,
   output logic resp_valid_out,
   output logic [7:0] resp_byte_out,
   output logic resp_done_out,
   output logic resp_stall_out
);

   // Register file and bus state.
   logic [31:0] ctrl_reg, intv_reg, cfg_fs_reg, cfg_hs_reg;
   logic [31:0] dev_fs_reg, dev_hs_reg, proto_reg, lang_reg;
   logic wr_pend_reg, last_stall_reg;
   logic [7:0] wr_addr_reg;
   logic ap_valid;
   // Request engine state.
   state_t state_reg, state_next;
   kind_t kind_reg, kind_next;
   logic [1:0] speed_reg;
   logic [BUF_AW-1:0] cnt_reg, eff_len_reg, eff_len_next;
   logic stall_next, accept, last_issue, v1_reg, done1_reg;
   logic [7:0] img [0:15];
   logic [7:0] rd_data;
   // Full descriptor length for each kind of answer.
   function automatic logic [BUF_AW-1:0] desc_len(input kind_t k);
      unique case (k)
         K_EP_IN, K_EP_OUT, K_EP_INT: desc_len = EP_LEN[BUF_AW-1:0];
         K_OTHER: desc_len = CFG_LEN[BUF_AW-1:0];
         K_QUAL: desc_len = QUAL_LEN[BUF_AW-1:0];
         default: desc_len = LANG_LEN[BUF_AW-1:0];
      endcase
   endfunction
   // A word transfer is taken in its address phase when hready is high.
   assign ap_valid = hsel_in && hready_in && htrans_in[1];
   assign accept = req_valid_in && (state_reg == ST_IDLE);
   // Every transfer completes at once with an OKAY answer.
   always_ff @(posedge ref_clk_in) begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
   end
   // Address phase capture; the write lands in the data phase.
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end else begin
         wr_pend_reg <= ap_valid && hwrite_in;
         wr_addr_reg <= haddr_in[7:0];
      end
   end
   // Read data is fetched in the address phase so it stands in the data
   // phase from a flop; unmapped offsets read as zero.
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         hrdata_out <= 32'h0000_0000;
      end else if (ap_valid && !hwrite_in) begin
         unique case (haddr_in[7:0])
            OFS_CTRL: hrdata_out <= ctrl_reg;
            OFS_STATUS: hrdata_out <= {28'h000_0000, speed_in,
                                       last_stall_reg, !req_ready_out};
            OFS_INTV: hrdata_out <= intv_reg;
            OFS_CFG_FS: hrdata_out <= cfg_fs_reg;
            OFS_CFG_HS: hrdata_out <= cfg_hs_reg;
            OFS_DEV_FS: hrdata_out <= dev_fs_reg;
            OFS_DEV_HS: hrdata_out <= dev_hs_reg;
            OFS_PROTO: hrdata_out <= proto_reg;
            OFS_LANG: hrdata_out <= lang_reg;
            default: hrdata_out <= 32'h0000_0000;
         endcase
      end
   end
   // Software image of the nonvolatile storage; resets to the defaults.
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         ctrl_reg <= RST_CTRL;
         intv_reg <= RST_INTV;
         cfg_fs_reg <= RST_CFG;
         cfg_hs_reg <= RST_CFG;
         dev_fs_reg <= RST_DEV;
         dev_hs_reg <= RST_DEV;
         proto_reg <= RST_PROTO;
         lang_reg <= RST_LANG;
      end else if (wr_pend_reg) begin
         unique case (wr_addr_reg)
            OFS_CTRL: ctrl_reg <= {29'h0000_0000, hwdata_in[2:0]};
            OFS_INTV: intv_reg <= {16'h0000, hwdata_in[15:0]};
            OFS_CFG_FS: cfg_fs_reg <= {8'h00, hwdata_in[23:0]};
            OFS_CFG_HS: cfg_hs_reg <= {8'h00, hwdata_in[23:0]};
            OFS_DEV_FS: dev_fs_reg <= hwdata_in;
            OFS_DEV_HS: dev_hs_reg <= hwdata_in;
            OFS_PROTO: proto_reg <= {16'h0000, hwdata_in[15:0]};
            OFS_LANG: lang_reg <= {15'h0000, hwdata_in[16:0]};
            default: ;
         endcase
      end
   end
   // Request decode. The language field of a string read plays no part.
   always_comb begin
      kind_next = K_LANG;
      stall_next = 1'b1;
      unique case (req_type_in)
         REQ_ENDPOINT: begin
            stall_next = (req_index_in > 8'h02);
            kind_next = (req_index_in == 8'h00) ? K_EP_IN :
               ((req_index_in == 8'h01) ? K_EP_OUT : K_EP_INT);
         end
         REQ_OTHER: begin
            kind_next = K_OTHER;
            stall_next = speed_in[1]; // R7
         end
         REQ_QUAL: begin
            kind_next = K_QUAL;
            stall_next = speed_in[1]; // R7
         end
         REQ_STRING: begin
            // R17 R20
            stall_next = (req_index_in != 8'h00) || !ctrl_reg[CTRL_NV_BIT]
                         || !lang_reg[LANG_PRESENT_BIT];
         end
         default: stall_next = 1'b1;
      endcase
      // Cut the answer to the host's requested length.
      eff_len_next = (req_len_in < {12'h000, desc_len(kind_next)}) ?
         req_len_in[BUF_AW-1:0] : desc_len(kind_next); // R21
   end
   // Image of the latched request; stored values count only when valid.
   always_comb begin
      logic fs, nv;
      logic [15:0] mps;
      logic [31:0] cfg_o, dev_o;
      logic [7:0] intv, prot;
      fs = (speed_reg == SPD_FS);
      nv = ctrl_reg[CTRL_NV_BIT];
      cfg_o = fs ? cfg_hs_reg : cfg_fs_reg; // R9
      dev_o = fs ? dev_hs_reg : dev_fs_reg; // R14
      prot = fs ? proto_reg[15:8] : proto_reg[7:0]; // R14
      mps = speed_reg[1] ? MPS_SS : (fs ? MPS_FS : MPS_HS); // R3
      intv = speed_reg[1] ? INTV_SS_DEF : // R6
         (nv ? (fs ? intv_reg[7:0] : intv_reg[15:8]) :
         (fs ? INTV_FS_DEF : INTV_HS_DEF));
      img = '{default: 8'h00};
      unique case (kind_reg)
         K_EP_IN, K_EP_OUT: begin
            img[0] = EP_LEN; // R1 R2
            img[1] = TYPE_EP;
            img[2] = (kind_reg == K_EP_IN) ? EP_IN_ADDR : EP_OUT_ADDR;
            img[3] = ATTR_BULK;
            img[4] = mps[7:0]; // R21
            img[5] = mps[15:8];
            img[6] = BULK_INTV; // R4
         end
         K_EP_INT: begin
            img[0] = EP_LEN; // R5
            img[1] = TYPE_EP;
            img[2] = EP_INT_ADDR;
            img[3] = ATTR_INTR;
            img[4] = MPS_INT[7:0];
            img[5] = MPS_INT[15:8];
            img[6] = intv; // R6
         end
         K_OTHER: begin
            img[0] = CFG_LEN; // R8
            img[1] = TYPE_OTHER;
            img[2] = OTHER_TOTAL[7:0];
            img[3] = OTHER_TOTAL[15:8];
            img[4] = NUM_IF;
            img[5] = CFG_VALUE;
            img[6] = nv ? cfg_o[7:0] : ICONF_DEF; // R11
            img[7] = nv ? cfg_o[15:8] : (ctrl_reg[CTRL_NOWAKE_BIT] ?
               (ATTR_DEF & ~ATTR_WAKE) : ATTR_DEF); // R11
            img[8] = nv ? cfg_o[23:16] : // R10
               (ctrl_reg[CTRL_SELF_BIT] ? PWR_SELF : PWR_BUS);
         end
         K_QUAL: begin
            img[0] = QUAL_LEN; // R12
            img[1] = TYPE_QUAL;
            img[2] = nv ? dev_o[7:0] : BCD_DEF[7:0]; // R13
            img[3] = nv ? dev_o[15:8] : BCD_DEF[15:8];
            img[4] = nv ? dev_o[23:16] : CLASS_DEF;
            img[5] = nv ? dev_o[31:24] : SUB_DEF;
            img[6] = nv ? prot : PROTO_DEF;
            img[7] = MPS0_DEF;
            img[8] = NUM_CFG;
            img[9] = QUAL_RSVD; // R12
         end
         default: begin
            img[0] = LANG_LEN; // R16
            img[1] = TYPE_STRING;
            img[2] = lang_reg[7:0]; // R18
            img[3] = lang_reg[15:8];
         end
      endcase
   end

   // Sequencer: build the whole image into the buffer, then stream it.
   assign last_issue = (eff_len_reg == '0) ||
                       (cnt_reg == eff_len_reg - 4'h1);
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: if (accept && !stall_next) state_next = ST_BUILD;
         ST_BUILD: if (cnt_reg == desc_len(kind_reg) - 4'h1)
            state_next = ST_SEND;
         ST_SEND: if (last_issue) state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         state_reg <= ST_IDLE;
         req_ready_out <= 1'b0;
      end else begin
         state_reg <= state_next;
         req_ready_out <= (state_next == ST_IDLE);
      end
   end
   // Byte counter, shared by the build and the send phases.
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in || state_next != state_reg) begin
         cnt_reg <= '0;
      end else if (state_reg != ST_IDLE) begin
         cnt_reg <= cnt_reg + 4'h1;
      end
   end
   // Request latch. Speed is held so an answer never mixes two speeds.
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         kind_reg <= K_EP_IN;
         speed_reg <= SPD_FS;
         eff_len_reg <= '0;
         last_stall_reg <= 1'b0;
      end else if (accept) begin
         kind_reg <= kind_next;
         speed_reg <= speed_in;
         eff_len_reg <= eff_len_next;
         last_stall_reg <= stall_next;
      end
   end
   desc_buf #(.WIDTH(8), .AW(BUF_AW)) u_buf (
      .ref_clk_in(ref_clk_in),
      .sys_rst_in(sys_rst_in),
      .wr_en_in(state_reg == ST_BUILD),
      .wr_addr_in(cnt_reg),
      .wr_data_in(img[cnt_reg]),
      .rd_addr_in(cnt_reg),
      .rd_data_out(rd_data)
   );
   // Output pipeline. The extra stage keeps every output on a local flop.
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         v1_reg <= 1'b0;
         done1_reg <= 1'b0;
         resp_valid_out <= 1'b0;
         resp_byte_out <= 8'h00;
         resp_done_out <= 1'b0;
         resp_stall_out <= 1'b0;
      end else begin
         v1_reg <= (state_reg == ST_SEND) && (eff_len_reg != '0); // R21
         done1_reg <= (state_reg == ST_SEND) && last_issue;
         resp_valid_out <= v1_reg;
         resp_byte_out <= rd_data;
         resp_done_out <= done1_reg;
         resp_stall_out <= accept && stall_next; // R7 R17
      end
   end

   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);
   logic in_build;
   assign in_build = (state_reg == ST_BUILD);
   a_speed_stall: assert property ( // R7
      accept && speed_in[1] && (req_type_in == REQ_QUAL ||
      req_type_in == REQ_OTHER) |=> resp_stall_out && req_ready_out)
      else $error("qualifier or other-speed not stalled at SuperSpeed");
   a_lang_stall: assert property ( // R17
      accept && req_type_in == REQ_STRING && req_index_in == 8'h00 &&
      !(ctrl_reg[CTRL_NV_BIT] && lang_reg[LANG_PRESENT_BIT])
      |=> resp_stall_out ##1 !resp_stall_out)
      else $error("language-ID read not stalled without strings");
   a_bulk_in_addr: assert property ( // R1
      in_build && kind_reg == K_EP_IN && cnt_reg == 4'h2
      |-> img[cnt_reg] == 8'h81)
      else $error("bulk-in endpoint address wrong");
   a_bulk_out_addr: assert property ( // R2
      in_build && kind_reg == K_EP_OUT && cnt_reg == 4'h2
      |-> img[cnt_reg] == 8'h02)
      else $error("bulk-out endpoint address wrong");
   a_bulk_mps: assert property ( // R3
      in_build && kind_reg != K_EP_INT && kind_reg < K_OTHER &&
      cnt_reg == 4'h5 |-> img[cnt_reg] == (speed_reg[1] ? 8'h04 :
      (speed_reg == SPD_FS ? 8'h00 : 8'h02)))
      else $error("bulk max packet high byte wrong for speed");
   a_int_intv: assert property ( // R6
      in_build && kind_reg == K_EP_INT && cnt_reg == 4'h6 &&
      !ctrl_reg[CTRL_NV_BIT] && speed_reg == SPD_HS
      |-> img[cnt_reg] == 8'h04)
      else $error("interrupt default interval wrong at high speed");
   a_other_power: assert property ( // R10
      in_build && kind_reg == K_OTHER && cnt_reg == 4'h8 &&
      !ctrl_reg[CTRL_NV_BIT] |-> img[cnt_reg] ==
      (ctrl_reg[CTRL_SELF_BIT] ? 8'h01 : 8'hFA))
      else $error("other-speed default power wrong");
   a_other_opp: assert property ( // R9
      in_build && kind_reg == K_OTHER && cnt_reg == 4'h7 &&
      ctrl_reg[CTRL_NV_BIT] && speed_reg == SPD_FS
      |-> img[cnt_reg] == cfg_hs_reg[15:8])
      else $error("other-speed not taken from the opposite speed");
   a_qual_rsvd: assert property ( // R12
      in_build && kind_reg == K_QUAL && cnt_reg == 4'h9
      |-> img[cnt_reg] == 8'h00)
      else $error("qualifier reserved byte not zero");
   a_send_done: assert property ( // R21
      state_reg == ST_SEND && last_issue |=> ##1 resp_done_out
      ##1 !resp_valid_out)
      else $error("done pulse misplaced after the last byte");

   c_lang_read: cover property (
      accept && req_type_in == REQ_STRING && !stall_next);
   c_qual_hs: cover property (
      accept && req_type_in == REQ_QUAL && speed_in == SPD_HS);
   c_trunc: cover property (
      accept && eff_len_next < desc_len(kind_next) && !stall_next);
   c_stall: cover property (resp_stall_out);

endmodule

// ===== usb_host_model.sv
`timescale 1ns/100ps
module usb_host_model (
   input wire logic ref_clk_in,
   input wire logic req_ready_in,
   input wire logic resp_valid_in,
   input wire logic [7:0] resp_byte_in,
   input wire logic resp_done_in,
   input wire logic resp_stall_in,
   output logic req_valid_out,
   output logic [7:0] req_type_out,
   output logic [7:0] req_index_out,
   output logic [15:0] req_langid_out,
   output logic [15:0] req_len_out
);
   // Request lines start quiet.
   initial begin
      {req_valid_out, req_type_out, req_index_out} = '0;
      {req_langid_out, req_len_out} = '0;
   end

   // Holds a request until taken, then gathers the answer.
   task automatic xfer(input logic [7:0] t, input logic [7:0] idx,
      input logic [15:0] len, output logic [79:0] got, output int n,
      output logic stl);
      int w;
      got = '0;
      n = 0;
      w = 0;
      @(posedge ref_clk_in);
      req_valid_out <= 1'b1;
      req_type_out <= t;
      req_index_out <= idx;
      req_langid_out <= 16'h1234;
      req_len_out <= len;
      do @(posedge ref_clk_in);
      while (req_ready_in !== 1'b1 && w++ < 100);
      // Released type, index and length lines carry inverted values so a late sample shows.
      req_valid_out <= 1'b0;
      req_type_out <= ~t;
      req_index_out <= ~idx;
      req_len_out <= ~len;
      for (w = 0; w < 60; w++) begin
         @(posedge ref_clk_in);
         if (resp_valid_in === 1'b1 && n < 10) begin
            got[8*n+:8] = resp_byte_in;
            n++;
         end
         if (resp_done_in === 1'b1 || resp_stall_in === 1'b1) break;
      end
      stl = resp_stall_in;
   endtask
endmodule

// ===== usb_desc_engine_bench.sv
`timescale 1ns/100ps
module usb_desc_engine_bench;
   import usb_desc_pkg::*;
   logic ref_clk_in, sys_rst_in, hsel_in, hwrite_in, hreadyout_out;
   logic hresp_out, req_valid_in, req_ready_out, resp_valid_out;
   logic resp_done_out, resp_stall_out;
   logic [1:0] htrans_in, speed_in;
   logic [2:0] hsize_in;
   logic [7:0] req_type_in, req_index_in, resp_byte_out;
   logic [15:0] req_langid_in, req_len_in;
   logic [31:0] haddr_in, hwdata_in, hrdata_out, rd;
   int error_cnt = 0;
   int tests_run = 0;
   int cyc = 0;

   usb_desc_engine u_dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
      .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
      .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
      .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
      .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
      .speed_in(speed_in), .req_valid_in(req_valid_in),
      .req_type_in(req_type_in), .req_index_in(req_index_in),
      .req_langid_in(req_langid_in), .req_len_in(req_len_in),
      .req_ready_out(req_ready_out), .resp_valid_out(resp_valid_out),
      .resp_byte_out(resp_byte_out), .resp_done_out(resp_done_out),
      .resp_stall_out(resp_stall_out));

   usb_host_model u_host (.ref_clk_in(ref_clk_in),
      .req_ready_in(req_ready_out), .resp_valid_in(resp_valid_out),
      .resp_byte_in(resp_byte_out), .resp_done_in(resp_done_out),
      .resp_stall_in(resp_stall_out), .req_valid_out(req_valid_in),
      .req_type_out(req_type_in), .req_index_out(req_index_in),
      .req_langid_out(req_langid_in), .req_len_out(req_len_in));

   // Free-running 25 MHz clock.
   initial begin
      ref_clk_in = 1'b0;
      forever #20 ref_clk_in = ~ref_clk_in;
   end

   // A hang ends the run; a clean run is far shorter.
   always @(posedge ref_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         finish_test();
      end
   end

   task automatic finish_test();
      if (error_cnt == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [79:0] got,
      input logic [79:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One single-word transfer, waiting on hready.
   task automatic ahb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd);
      @(posedge ref_clk_in);
      haddr_in <= {24'h00_0000, a};
      hwrite_in <= wr;
      htrans_in <= 2'b10;
      do @(posedge ref_clk_in); while (hreadyout_out !== 1'b1);
      htrans_in <= 2'b00;
      hwdata_in <= wd;
      do @(posedge ref_clk_in); while (hreadyout_out !== 1'b1);
      rd = hrdata_out;
      chk("hresp", {79'h0, hresp_out}, 80'h0);
   endtask

   // A length d of zero expects a stall.
   task automatic desc(input string nm, input logic [7:0] t,
      input logic [7:0] idx, input logic [15:0] len,
      input logic [79:0] exp, input int d);
      logic [79:0] got;
      int n;
      int l;
      logic stl;
      l = (len < d) ? len : d;
      u_host.xfer(t, idx, len, got, n, stl);
      chk({nm, " stall"}, {79'h0, stl}, {79'h0, d == 0});
      chk({nm, " count"}, 80'(n), 80'(l));
      chk(nm, got, exp & ((80'h1 << (8 * l)) - 80'h1));
   endtask

   function automatic logic [79:0] ep(input logic [7:0] a,
      input logic [7:0] at, input logic [15:0] m, input logic [7:0] iv);
      return {24'h0, iv, m, at, a, TYPE_EP, EP_LEN};
   endfunction

   function automatic logic [79:0] oth(input logic [7:0] ic,
      input logic [7:0] at, input logic [7:0] pw);
      return {8'h00, pw, at, ic, CFG_VALUE, NUM_IF, OTHER_TOTAL,
         TYPE_OTHER, CFG_LEN};
   endfunction

   function automatic logic [79:0] qual(input logic [15:0] bcd,
      input logic [7:0] cl, input logic [7:0] sb, input logic [7:0] pr);
      return {QUAL_RSVD, NUM_CFG, MPS0_DEF, pr, sb, cl, bcd, TYPE_QUAL,
         QUAL_LEN};
   endfunction

   task automatic t_regs();
      ahb(1'b0, OFS_INTV, 32'h0);
      chk("intv rst", {48'h0, rd}, {48'h0, RST_INTV});
      ahb(1'b0, OFS_CFG_FS, 32'h0);
      chk("cfg rst", {48'h0, rd}, {48'h0, RST_CFG});
      ahb(1'b0, 8'h40, 32'h0);
      chk("unmapped", {48'h0, rd}, 80'h0);
   endtask

   task automatic t_endpoints();
      logic [7:0] iv [3];
      iv = '{INTV_FS_DEF, INTV_HS_DEF, INTV_SS_DEF};
      speed_in <= SPD_FS;
      desc("bin fs", REQ_ENDPOINT, 8'h00, 16'h00FF,
         ep(EP_IN_ADDR, ATTR_BULK, MPS_FS, BULK_INTV), 7);
      speed_in <= SPD_HS;
      desc("bout hs", REQ_ENDPOINT, 8'h01, 16'h0007,
         ep(EP_OUT_ADDR, ATTR_BULK, MPS_HS, BULK_INTV), 7);
      speed_in <= 2'h2;
      desc("bin ss", REQ_ENDPOINT, 8'h00, 16'h0040,
         ep(EP_IN_ADDR, ATTR_BULK, MPS_SS, BULK_INTV), 7);
      desc("bad ep", REQ_ENDPOINT, 8'h03, 16'h0040, 80'h0, 0);
      for (int s = 0; s < 3; s++) begin
         speed_in <= 2'(s);
         desc("intr", REQ_ENDPOINT, 8'h02, 16'h0040,
            ep(EP_INT_ADDR, ATTR_INTR, MPS_INT, iv[s]), 7);
      end
   endtask

   task automatic t_usb2_only();
      desc("oth ss", REQ_OTHER, 8'h00, 16'h0040, 80'h0, 0);
      desc("qual ss", REQ_QUAL, 8'h00, 16'h0040, 80'h0, 0);
      speed_in <= SPD_FS;
      desc("lang off", REQ_STRING, 8'h00, 16'h00FF, 80'h0, 0);
      desc("oth fs", REQ_OTHER, 8'h00, 16'h0040,
         oth(ICONF_DEF, ATTR_DEF, PWR_BUS), 9);
      desc("oth cut", REQ_OTHER, 8'h00, 16'h0003,
         oth(ICONF_DEF, ATTR_DEF, PWR_BUS), 9);
      desc("qual zero", REQ_QUAL, 8'h00, 16'h0000, 80'h0, 10);
      speed_in <= SPD_HS;
      desc("qual hs", REQ_QUAL, 8'h00, 16'h0040,
         qual(BCD_DEF, CLASS_DEF, SUB_DEF, PROTO_DEF), 10);
      ahb(1'b1, OFS_CTRL, 32'h0000_0002);
      desc("oth self", REQ_OTHER, 8'h00, 16'h0040,
         oth(ICONF_DEF, ATTR_DEF, PWR_SELF), 9);
   endtask

   // Stored values differ per speed so a wrong speed pick shows up.
   task automatic t_stored();
      ahb(1'b1, OFS_CTRL, 32'h0000_0001);
      ahb(1'b1, OFS_INTV, 32'h0000_0802);
      ahb(1'b1, OFS_CFG_HS, 32'h0032_A000);
      ahb(1'b1, OFS_CFG_FS, 32'h0064_C000);
      ahb(1'b1, OFS_DEV_FS, 32'h00FF_0200);
      ahb(1'b1, OFS_PROTO, 32'h0000_FF01);
      ahb(1'b0, OFS_INTV, 32'h0);
      chk("intv wr", {48'h0, rd}, 80'h0802);
      desc("intr hs", REQ_ENDPOINT, 8'h02, 16'h0040,
         ep(EP_INT_ADDR, ATTR_INTR, MPS_INT, 8'h08), 7);
      desc("oth hs", REQ_OTHER, 8'h00, 16'h0040,
         oth(8'h00, 8'hC0, 8'h64), 9);
      desc("qual st", REQ_QUAL, 8'h00, 16'h0040,
         qual(16'h0200, 8'hFF, 8'h00, 8'h01), 10);
      speed_in <= SPD_FS;
      desc("intr fs", REQ_ENDPOINT, 8'h02, 16'h0040,
         ep(EP_INT_ADDR, ATTR_INTR, MPS_INT, 8'h02), 7);
      desc("oth st", REQ_OTHER, 8'h00, 16'h0040,
         oth(8'h00, 8'hA0, 8'h32), 9);
   endtask

   task automatic t_lang();
      ahb(1'b1, OFS_LANG, 32'h0001_0409);
      desc("lang", REQ_STRING, 8'h00, 16'h00FF,
         {48'h0, 16'h0409, TYPE_STRING, LANG_LEN}, 4);
      ahb(1'b1, OFS_LANG, 32'h0000_0409);
      desc("lang none", REQ_STRING, 8'h00, 16'h00FF, 80'h0, 0);
   endtask

   // Reset, then the scenarios.
   initial begin
      sys_rst_in = 1'b1;
      {hsel_in, hsize_in} = 4'b1010;
      {haddr_in, htrans_in, hwrite_in, hwdata_in} = '0;
      speed_in = SPD_FS;
      repeat (4) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      t_regs();
      t_endpoints();
      t_usb2_only();
      t_stored();
      t_lang();
      finish_test();
   end
endmodule
